// ---- verilog/tmc_pkg.sv ----
// shared constants of the trigger matching engine
package tmc_pkg;
	// register byte offsets
	localparam logic [11:0] ADDR_CTRL  = 12'h000;
	localparam logic [11:0] ADDR_WIN   = 12'h004;
	localparam logic [11:0] ADDR_MARG  = 12'h008;
	localparam logic [11:0] ADDR_LIMIT = 12'h00C;
	localparam logic [11:0] ADDR_OFFS  = 12'h010;
	localparam logic [11:0] ADDR_STAT  = 12'h014;
	localparam logic [1:0]  LUT_PAGE   = 2'h1;
	// control field positions
	localparam int CTRL_REL_BIT = 1;
	localparam int CTRL_LIM_BIT = 2;
	localparam int CTRL_INL_BIT = 5;
	localparam int CTRL_RES_LSB = 6;
	// paired 12-bit fields sit at bit 0 and bit 16 of a word
	localparam int FLD_HI_LSB   = 16;
	// reset values
	localparam logic [7:0]  RST_CTRL   = 8'h20;
	localparam logic [11:0] RST_WIDTH  = 12'h014;
	localparam logic [11:0] RST_OFFSET = 12'hFD8;
	localparam logic [11:0] RST_SEARCH = 12'h008;
	localparam logic [11:0] RST_REJECT = 12'h004;
	localparam logic [7:0]  RST_LIMIT  = 8'hFF;
	// resolution codes
	localparam logic [1:0] RES_800 = 2'h0;
	localparam logic [1:0] RES_200 = 2'h1;
	localparam logic [1:0] RES_100 = 2'h2;
	// time layout: coarse cycles above fine bins
	localparam int COARSE_W = 12;
	localparam int FINE_W   = 7;
	localparam int HIT_W    = COARSE_W + FINE_W;
	// trigger delay for windows at or after the trigger, in cycles
	localparam logic [11:0] TRIG_DELAY_CYC = 12'h028;
	localparam int TRIG_DEPTH = 16;
	// readout word types in bits 31:28
	localparam logic [3:0] W_DATA = 4'h0;
	localparam logic [3:0] W_HDR  = 4'h1;
	localparam logic [3:0] W_ERR  = 4'h2;
	localparam logic [3:0] W_TRL  = 4'h3;
endpackage

// ---- verilog/tmc_trig_fifo.sv ----
// trigger fifo holding event number and trigger time tag
`timescale 1ns/10ps
module tmc_trig_fifo import tmc_pkg::*; #(
	parameter int W     = 24,
	parameter int DEPTH = TRIG_DEPTH
) (
	// clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	// fill and drain
	input  wire logic                   push,
	input  wire logic [W-1:0]           din,
	input  wire logic                   pop,
	output logic      [W-1:0]           dout,
	output logic                        empty,
	output logic                        full,
	output logic [$clog2(DEPTH):0]      count
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wrPtr;
	logic [AW:0]  rdPtr;

	assign count = wrPtr - rdPtr;
	assign empty = (wrPtr == rdPtr);
	assign full  = (count == DEPTH[AW:0]);
	assign dout  = mem[rdPtr[AW-1:0]];

	// a push into a full fifo is dropped, the caller flags it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wrPtr <= '0;
		end else if (push && !full) begin
			mem[wrPtr[AW-1:0]] <= din;
			wrPtr <= wrPtr + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			rdPtr <= '0;
		else if (pop && !empty)
			rdPtr <= rdPtr + 1'b1;
	end

	AST_FIFO_BOUND: assert property (@(posedge ref_clk) disable iff (rst)
		push && full && !pop |=> count == DEPTH[AW:0])
		else $error("trigger fifo count past its depth");
endmodule

// ---- verilog/tmc_inl_corr.sv ----
// periodic lookup-table non-linearity correction of hit times
`timescale 1ns/10ps
module tmc_inl_corr import tmc_pkg::*; (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// configuration and table load
	input  wire logic             enable,
	input  wire logic [1:0]       resSel,
	input  wire logic             lutWe,
	input  wire logic [7:0]       lutAddr,
	input  wire logic [7:0]       lutData,
	// raw hits
	input  wire logic             inValid,
	input  wire logic [3:0]       inChan,
	input  wire logic [HIT_W-1:0] inTime,
	// corrected hits
	output logic                  outValid,
	output logic      [3:0]       outChan,
	output logic      [HIT_W-1:0] outTime
);
	// one clock period of bins, loaded by software from stored calibration
	logic [7:0]       lut [256];
	logic [7:0]       idx;
	logic [HIT_W-1:0] corr;

	always_ff @(posedge ref_clk) begin
		if (lutWe)
			lut[lutAddr] <= lutData;
	end

	always_comb begin
		idx  = inTime[7:0];
		corr = inTime;
		if (resSel == RES_200)
			idx = {1'b0, inTime[6:0]};
		if (enable && (resSel == RES_200 || resSel == RES_100))
			corr = inTime - {{(HIT_W-8){lut[idx][7]}}, lut[idx]};
		// 800 ps keeps the raw value
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			outValid <= 1'b0;
			outChan  <= '0;
			outTime  <= '0;
		end else begin
			outValid <= inValid;
			outChan  <= inChan;
			outTime  <= corr;
		end
	end

	AST_INL_BYPASS: assert property (@(posedge ref_clk) disable iff (rst)
		inValid && !enable |=> outTime == $past(inTime))
		else $error("disabled correction changed the time");
	AST_INL_800: assert property (@(posedge ref_clk) disable iff (rst)
		inValid && resSel == RES_800 |=> outTime == $past(inTime))
		else $error("800 ps time was corrected");
endmodule

// ---- verilog/tmc_top.sv ----
// trigger matching engine with register slave and readout stream
// Behaviour
// - match trigger tags from the trigger fifo against buffered hits
// - four programmable knobs: width, offset, search and reject margins
// - matching works in whole 25 ns clock cycles
// - window offset is a signed distance from trigger to window start
// - windows at or after the trigger wait 40 cycles before search
// - search spans the window plus a margin, default eight cycles
// - with no triggers pending, old hits go by the reject counter
// - events sit between header (event, tag) and trailer (event, count)
// - hit times absolute by default, optionally window-relative
// - optional cap of hits per event, excess flagged at event end
// - overflow, parity or truncation gives an error flag word
// - a hit goes into every event whose window holds it
// - window width and offset are 12-bit cycle counts
// - non-linearity corrected by subtracting a per-bin table entry
// - 200 ps uses 128 entries indexed by the low seven bits
// - 100 ps uses 256 entries indexed by the low eight bits
// - no correction at 800 ps
// - control bit 5 enables correction, set after reset
// - pending triggers held in a sixteen word fifo
// - bunch reset loads coarse and reject counters, event reset events
`timescale 1ns/10ps
module tmc_top import tmc_pkg::*; #(
	parameter int HIT_DEPTH = 16
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// ahb-lite slave
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic      [31:0]      hrdata,
	output logic                  hresp,
	// trigger and reset pins
	input  wire logic             trigIn,
	input  wire logic             bunchRstIn,
	input  wire logic             eventRstIn,
	// hits from the measurement logic
	input  wire logic             hitValid,
	input  wire logic [3:0]       hitChan,
	input  wire logic [HIT_W-1:0] hitTime,
	input  wire logic             hitParityErr,
	// readout stream
	input  wire logic             roReady,
	output logic                  roValid,
	output logic      [31:0]      roData
);
	localparam int AW = $clog2(HIT_DEPTH);

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_HEAD  = 3'b001,
		S_SCAN  = 3'b010,
		S_ERR   = 3'b011,
		S_TRAIL = 3'b100
	} tmc_state_t;

	// true when a lies strictly after b on the wrapping coarse scale
	function automatic logic after(input logic [11:0] a, input logic [11:0] b);
		logic [11:0] d;
		d = a - b;
		return (d != 12'h000) && !d[11];
	endfunction

	logic [7:0]  ctrlReg;
	logic [11:0] winWidth, winOffset, searchMargin, rejectMargin;
	logic [11:0] coarseOffset, eventOffset;
	logic [7:0]  hitLimit;
	logic        wrPend;
	logic [11:0] wrAddr;
	logic [31:0] rdMux;
	logic [2:0]  pinMeta, pinSync, pinLast, pinRise;
	logic [11:0] coarse, rejCnt, eventCnt;
	logic        trigEmpty, trigFull;
	logic [23:0] trigDout;
	logic [4:0]  trigCount;
	logic        trigPop;
	logic        inlValid;
	logic [3:0]  inlChan;
	logic [HIT_W-1:0] inlTime;
	logic [HIT_W+3:0] hitMem [HIT_DEPTH];
	logic [AW:0] wrPtr, rdPtr, scanPtr;
	logic        hitFull, purge;
	logic [3:0]  errFlags;
	tmc_state_t  state;
	logic [11:0] curTag, curEvent, curStart, wordCnt;
	logic [11:0] headStart, age, tailC, scanC, searchEnd;
	logic [12:0] lateSum;
	logic        straddle, due, inWin, limitReached, canEmit, emit;
	logic [HIT_W+3:0] scanHit, tailHit;
	logic [HIT_W-1:0] outTime;
	logic [31:0] word;

	// bus slave: always ready, read data staged in the address phase
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wrPend    <= 1'b0;
			wrAddr    <= '0;
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wrPend <= hsel && hready && htrans[1] && hwrite;
			wrAddr <= haddr[11:0];
			if (hsel && hready && htrans[1] && !hwrite)
				hrdata <= rdMux;
		end
	end

	always_comb begin
		unique case (haddr[11:0])
			ADDR_CTRL:  rdMux = {24'h000000, ctrlReg};
			ADDR_WIN:   rdMux = {4'h0, winOffset, 4'h0, winWidth};
			ADDR_MARG:  rdMux = {4'h0, rejectMargin, 4'h0, searchMargin};
			ADDR_LIMIT: rdMux = {24'h000000, hitLimit};
			ADDR_OFFS:  rdMux = {4'h0, eventOffset, 4'h0, coarseOffset};
			ADDR_STAT:  rdMux = {trigCount, errFlags, state, 8'h00, eventCnt};
			default:    rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrlReg      <= RST_CTRL;
			winWidth     <= RST_WIDTH;
			winOffset    <= RST_OFFSET;
			searchMargin <= RST_SEARCH;
			rejectMargin <= RST_REJECT;
			hitLimit     <= RST_LIMIT;
			coarseOffset <= '0;
			eventOffset  <= '0;
		end else if (wrPend) begin
			unique case (wrAddr)
				ADDR_CTRL: ctrlReg <= hwdata[7:0];
				ADDR_WIN: begin
					winWidth  <= hwdata[11:0];
					winOffset <= hwdata[FLD_HI_LSB +: 12];
				end
				ADDR_MARG: begin
					searchMargin <= hwdata[11:0];
					rejectMargin <= hwdata[FLD_HI_LSB +: 12];
				end
				ADDR_LIMIT: hitLimit <= hwdata[7:0];
				ADDR_OFFS: begin
					coarseOffset <= hwdata[11:0];
					eventOffset  <= hwdata[FLD_HI_LSB +: 12];
				end
				default: ;
			endcase
		end
	end

	// pins come from outside the clock domain
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pinMeta <= '0;
			pinSync <= '0;
			pinLast <= '0;
		end else begin
			pinMeta <= {eventRstIn, bunchRstIn, trigIn};
			pinSync <= pinMeta;
			pinLast <= pinSync;
		end
	end
	assign pinRise = pinSync & ~pinLast;

	// the trigger tag counter is the coarse counter itself
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			coarse <= '0;
			rejCnt <= 12'h000 - RST_REJECT;
		end else if (pinRise[1]) begin
			coarse <= coarseOffset;
			rejCnt <= coarseOffset - rejectMargin;
		end else begin
			coarse <= coarse + 1'b1;
			rejCnt <= rejCnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			eventCnt <= '0;
		else if (pinRise[2])
			eventCnt <= eventOffset;
		else if (pinRise[0])
			eventCnt <= eventCnt + 1'b1;
	end

	tmc_trig_fifo #(
		.W     (24),
		.DEPTH (TRIG_DEPTH)
	) u_trig (
		.ref_clk (ref_clk),
		.rst     (rst),
		.push    (pinRise[0]),
		.din     ({eventCnt, coarse}),
		.pop     (trigPop),
		.dout    (trigDout),
		.empty   (trigEmpty),
		.full    (trigFull),
		.count   (trigCount)
	);

	tmc_inl_corr u_inl (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.enable   (ctrlReg[CTRL_INL_BIT]),
		.resSel   (ctrlReg[CTRL_RES_LSB +: 2]),
		.lutWe    (wrPend && wrAddr[11:10] == LUT_PAGE),
		.lutAddr  (wrAddr[9:2]),
		.lutData  (hwdata[7:0]),
		.inValid  (hitValid),
		.inChan   (hitChan),
		.inTime   (hitTime),
		.outValid (inlValid),
		.outChan  (inlChan),
		.outTime  (inlTime)
	);

	// hit staging buffer
	assign hitFull = (wrPtr - rdPtr) == HIT_DEPTH[AW:0];
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wrPtr <= '0;
		end else if (inlValid && !hitFull) begin
			hitMem[wrPtr[AW-1:0]] <= {inlChan, inlTime};
			wrPtr <= wrPtr + 1'b1;
		end
	end

	// purging only while idle keeps the scan pointer inside live data
	// reject point trails the window start, so a later trigger keeps its hits
	assign tailHit = hitMem[rdPtr[AW-1:0]];
	assign tailC   = tailHit[HIT_W-1:FINE_W];
	assign purge   = (state == S_IDLE) && (rdPtr != wrPtr) &&
		(trigEmpty ? after(rejCnt + winOffset, tailC)
		           : after(headStart - searchMargin, tailC));
	always_ff @(posedge ref_clk) begin
		if (rst)
			rdPtr <= '0;
		else if (purge)
			rdPtr <= rdPtr + 1'b1;
	end

	// head trigger: signed offset, delay only for late windows
	assign headStart = trigDout[11:0] + winOffset;
	assign lateSum   = {winOffset[11], winOffset} + {1'b0, winWidth};
	assign straddle  = !winOffset[11] || (lateSum != 13'h0000 && !lateSum[12]);
	assign age       = coarse - trigDout[11:0];
	assign due       = !straddle || age >= TRIG_DELAY_CYC;

	assign scanHit   = hitMem[scanPtr[AW-1:0]];
	assign scanC     = scanHit[HIT_W-1:FINE_W];
	assign inWin     = (scanC - curStart) < winWidth;
	assign searchEnd = curStart + winWidth + searchMargin;
	assign limitReached = ctrlReg[CTRL_LIM_BIT] &&
		wordCnt >= {4'h0, hitLimit};
	assign outTime   = ctrlReg[CTRL_REL_BIT] ?
		scanHit[HIT_W-1:0] - {curStart, {FINE_W{1'b0}}}
		: scanHit[HIT_W-1:0];
	assign canEmit   = !roValid || roReady;

	always_comb begin
		emit = 1'b0;
		word = 32'h00000000;
		unique case (state)
			S_HEAD: begin
				emit = canEmit;
				word = {W_HDR, curEvent, 4'h0, curTag};
			end
			S_SCAN: begin
				emit = canEmit && scanPtr != wrPtr && inWin && !limitReached;
				word = {W_DATA, scanHit[HIT_W+3:HIT_W], 5'h00, outTime};
			end
			S_ERR: begin
				emit = canEmit && (errFlags != 4'h0);
				word = {W_ERR, 24'h000000, errFlags};
			end
			S_TRAIL: begin
				emit = canEmit;
				word = {W_TRL, curEvent, 4'h0, wordCnt};
			end
			default: ;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			roValid <= 1'b0;
			roData  <= '0;
		end else if (emit) begin
			roValid <= 1'b1;
			roData  <= word;
		end else if (roReady) begin
			roValid <= 1'b0;
		end
	end

	// flags: limit, parity, trigger overflow, hit overflow; set wins
	always_ff @(posedge ref_clk) begin
		if (rst)
			errFlags <= '0;
		else
			errFlags <= (errFlags & {4{!trigPop}}) | {
				state == S_SCAN && scanPtr != wrPtr && inWin && limitReached,
				hitParityErr,
				pinRise[0] && trigFull,
				inlValid && hitFull};
	end

	assign trigPop = (state == S_TRAIL) && emit;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state    <= S_IDLE;
			curTag   <= '0;
			curEvent <= '0;
			curStart <= '0;
			scanPtr  <= '0;
			wordCnt  <= '0;
		end else begin
			unique case (state)
				S_IDLE: if (!trigEmpty && due) begin
					curTag   <= trigDout[11:0];
					curEvent <= trigDout[23:12];
					curStart <= headStart;
					state    <= S_HEAD;
				end
				S_HEAD: if (emit) begin
					// rescan from the tail so overlapping events share hits
					scanPtr <= rdPtr;
					wordCnt <= '0;
					state   <= S_SCAN;
				end
				S_SCAN: begin
					if (scanPtr != wrPtr) begin
						if (!inWin || limitReached) begin
							scanPtr <= scanPtr + 1'b1;
						end else if (emit) begin
							scanPtr <= scanPtr + 1'b1;
							wordCnt <= wordCnt + 1'b1;
						end
					end else if (!after(searchEnd, coarse)) begin
						state <= S_ERR;
					end
				end
				S_ERR: if (errFlags == 4'h0 || emit)
					state <= S_TRAIL;
				S_TRAIL: if (emit)
					state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence sHeadOut;
		state == S_HEAD && canEmit;
	endsequence
	sequence sHeadWord;
		roValid && roData[31:28] == W_HDR && roData[11:0] == curTag;
	endsequence

	AST_HDR_WORD: assert property (sHeadOut |=> sHeadWord ##0 state == S_SCAN)
		else $error("header word missing at event start");
	AST_TRL_WORD: assert property (state == S_TRAIL && canEmit |=>
		roData[31:28] == W_TRL && roData[11:0] == $past(wordCnt))
		else $error("trailer word or count wrong");
	AST_DELAY: assert property (state == S_IDLE && !trigEmpty && straddle
		&& age < TRIG_DELAY_CYC |=> state == S_IDLE)
		else $error("late window searched before the delay");
	AST_LIMIT: assert property (emit && state == S_SCAN |->
		!ctrlReg[CTRL_LIM_BIT] || wordCnt < {4'h0, hitLimit})
		else $error("hit emitted past the cap");
	AST_ERR_WORD: assert property (state == S_ERR && errFlags != 4'h0 &&
		canEmit |=> roData[31:28] == W_ERR && state == S_TRAIL)
		else $error("error word not emitted");
	AST_PURGE: assert property (rdPtr != $past(rdPtr) |->
		$past(state) == S_IDLE)
		else $error("hit dropped outside idle");
	AST_BUNCH: assert property (pinRise[1] |=> coarse == $past(coarseOffset)
		##1 coarse == $past(coarseOffset, 2) + 12'h001)
		else $error("bunch reset did not load coarse counter");
	AST_STALL: assert property (roValid && !roReady |=>
		roValid && $stable(roData))
		else $error("readout word lost under back-pressure");
endmodule

// ---- bench/tmc_ro_master.sv ----
// readout master model draining the event stream
`timescale 1ns/10ps
module tmc_ro_master (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// stall control from the bench
	input  wire logic        stall,
	// readout stream
	input  wire logic        roValid,
	input  wire logic [31:0] roData,
	output logic             roReady
);
	logic [31:0] q[$];

	// stalling every other cycle exercises the engine's hold path
	always @(posedge ref_clk) begin
		if (rst) begin
			roReady <= 1'h0;
		end else begin
			roReady <= stall ? ~roReady : 1'h1;
			if (roValid && roReady) begin
				q.push_back(roData);
			end
		end
	end
endmodule

// ---- bench/tmc_top_tb.sv ----
// self-checking bench of the trigger matching engine
`timescale 1ns/10ps
module tmc_top_tb import tmc_pkg::*;;
	logic             ref_clk = 1'h0;
	logic             rst = 1'h1;
	logic             hsel = 1'h0;
	logic [31:0]      haddr = 32'h0;
	logic [1:0]       htrans = 2'h0;
	logic             hwrite = 1'h0;
	logic [2:0]       hsize = 3'h2;
	logic [31:0]      hwdata = 32'h0;
	logic             hready;
	logic             hreadyout;
	logic [31:0]      hrdata;
	logic             hresp;
	logic             trigIn = 1'h0;
	logic             bunchRstIn = 1'h0;
	logic             eventRstIn = 1'h0;
	logic             hitValid = 1'h0;
	logic [3:0]       hitChan = 4'h0;
	logic [HIT_W-1:0] hitTime = 19'h0;
	logic             hitParityErr = 1'h0;
	logic             roReady;
	logic             roValid;
	logic [31:0]      roData;
	logic             stall = 1'h0;
	logic             relMode = 1'h0;
	int               err_count = 0;
	int               checks = 0;
	int               cyc = 0;
	int               b0 = 0;
	int               ev = 0;
	int               lastTrig = 0;
	logic [31:0]      expData[$];

	// the single slave's hreadyout is the bus's hready
	assign hready = hreadyout;

	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;

	tmc_top u_dut (
		.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .trigIn(trigIn),
		.bunchRstIn(bunchRstIn), .eventRstIn(eventRstIn),
		.hitValid(hitValid), .hitChan(hitChan), .hitTime(hitTime),
		.hitParityErr(hitParityErr), .roReady(roReady),
		.roValid(roValid), .roData(roData)
	);

	tmc_ro_master u_ro (
		.ref_clk(ref_clk), .rst(rst), .stall(stall),
		.roValid(roValid), .roData(roData), .roReady(roReady)
	);

	function automatic int now();
		return cyc - b0;
	endfunction

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'h1) begin
			err_count++;
			$display("[FAIL] %0t ns %s", $time, msg);
		end
	endtask

	// one single AHB-Lite transfer; waits on hready in both phases
	task automatic ahb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		hsel <= 1'h1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge ref_clk);
		while (hready !== 1'h1) @(posedge ref_clk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0;
		@(posedge ref_clk);
		while (hready !== 1'h1) @(posedge ref_clk);
		r = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'h1, a, d, r);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'h0, a, 32'h0, r);
		chk(r === e, "register read value");
		chk(hresp === 1'h0, "bus response not okay");
	endtask

	task automatic hit(input logic [3:0] ch, input int c,
		input logic [6:0] f);
		@(posedge ref_clk);
		hitValid <= 1'h1;
		hitChan <= ch;
		hitTime <= {c[11:0], f};
		@(posedge ref_clk);
		hitValid <= 1'h0;
	endtask

	task automatic trig();
		@(posedge ref_clk);
		lastTrig = now();
		trigIn <= 1'h1;
		@(posedge ref_clk);
		trigIn <= 1'h0;
	endtask

	task automatic get(output logic [31:0] w);
		int n;
		n = 0;
		w = 32'h0;
		while (u_ro.q.size() == 0 && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
		if (u_ro.q.size() == 0)
			chk(1'h0, "readout word missing");
		else
			w = u_ro.q.pop_front();
	endtask

	// header, expected data, optional error word, trailer
	task automatic check_event(input int t, input logic [3:0] fl);
		logic [31:0] w;
		logic [11:0] d;
		logic [11:0] n;
		n = 12'(expData.size());
		get(w);
		d = w[11:0] - t[11:0];
		chk(w[31:16] === {W_HDR, ev[11:0]} && (d <= 12'h004 ||
			d >= 12'hFFC), "event header");
		foreach (expData[i]) begin
			get(w);
			if (relMode)
				chk(w[31:19] === expData[i][31:19] &&
					w[6:0] === expData[i][6:0] && w[18:7] >= 12'h006 &&
					w[18:7] <= 12'h00E, "relative hit time");
			else
				chk(w === expData[i], "hit data word");
		end
		if (fl != 4'h0) begin
			get(w);
			chk(w === {W_ERR, 24'h0, fl}, "error word");
		end
		get(w);
		chk(w === {W_TRL, ev[11:0], 4'h0, n}, "event trailer");
		ev++;
	endtask

	// hit inside the default window, one late hit outside the search span
	task automatic std_event(input logic [3:0] ch, input logic [6:0] f,
		input logic [6:0] sub, input logic [3:0] fl, input logic two,
		input logic dbl);
		int c0;
		int t1;
		c0 = now() | 1;
		hit(ch, c0, f);
		if (two)
			hit(ch + 4'h1, c0 + 1, f);
		expData.push_back({W_DATA, ch, 5'h0, c0[11:0], f} - {25'h0, sub});
		while (now() < c0 + 25) @(posedge ref_clk);
		hit(ch, c0 + 25, f);
		while (now() < c0 + 30) @(posedge ref_clk);
		trig();
		t1 = lastTrig;
		if (dbl)
			trig();
		check_event(t1, fl);
		if (dbl)
			check_event(lastTrig, fl);
		expData.delete();
		// let the reject counter clear the late hit before the next event
		repeat (100) @(posedge ref_clk);
	endtask

	initial begin
		int n;
		int t;
		repeat (5) @(posedge ref_clk);
		rst <= 1'h0;
		rd_chk(ADDR_CTRL, 32'h0000_0020);
		rd_chk(ADDR_WIN, 32'h0FD8_0014);
		rd_chk(ADDR_MARG, 32'h0004_0008);
		rd_chk(ADDR_LIMIT, 32'h0000_00FF);
		rd_chk(ADDR_OFFS, 32'h0000_0000);
		rd_chk(ADDR_STAT, 32'h0000_0000);
		wr(ADDR_WIN, 32'h0FE0_0010);
		rd_chk(ADDR_WIN, 32'h0FE0_0010);
		wr(ADDR_WIN, 32'h0FD8_0014);
		wr(12'h020, 32'h1234_5678);
		rd_chk(12'h020, 32'h0000_0000);
		$display("test registers done");
		@(posedge ref_clk);
		bunchRstIn <= 1'h1;
		eventRstIn <= 1'h1;
		b0 = cyc;
		@(posedge ref_clk);
		bunchRstIn <= 1'h0;
		eventRstIn <= 1'h0;
		repeat (4) @(posedge ref_clk);
		stall <= 1'h1;
		std_event(4'h3, 7'h05, 7'h00, 4'h0, 1'h0, 1'h0);
		$display("test basic event done");
		wr(ADDR_CTRL, 32'h0000_0060);
		wr(12'h414, 32'h0000_0003);
		std_event(4'h1, 7'h05, 7'h03, 4'h0, 1'h0, 1'h0);
		wr(ADDR_CTRL, 32'h0000_00A0);
		wr(12'h614, 32'h0000_0002);
		std_event(4'h1, 7'h05, 7'h02, 4'h0, 1'h0, 1'h0);
		wr(ADDR_CTRL, 32'h0000_0080);
		std_event(4'h1, 7'h05, 7'h00, 4'h0, 1'h0, 1'h0);
		$display("test correction done");
		wr(ADDR_CTRL, 32'h0000_0004);
		wr(ADDR_LIMIT, 32'h0000_0001);
		@(posedge ref_clk);
		hitParityErr <= 1'h1;
		@(posedge ref_clk);
		hitParityErr <= 1'h0;
		std_event(4'h6, 7'h10, 7'h00, 4'hC, 1'h1, 1'h0);
		$display("test hit limit done");
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_LIMIT, 32'h0000_00FF);
		wr(ADDR_OFFS, 32'h0005_0000);
		@(posedge ref_clk);
		eventRstIn <= 1'h1;
		@(posedge ref_clk);
		eventRstIn <= 1'h0;
		repeat (4) @(posedge ref_clk);
		ev = 5;
		std_event(4'h8, 7'h22, 7'h00, 4'h0, 1'h0, 1'h1);
		rd_chk(ADDR_STAT, 32'h0000_0007);
		$display("test overlap done");
		wr(ADDR_CTRL, 32'h0000_0002);
		relMode = 1'h1;
		std_event(4'h9, 7'h33, 7'h00, 4'h0, 1'h0, 1'h0);
		relMode = 1'h0;
		$display("test relative time done");
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_WIN, 32'h0000_0014);
		wr(ADDR_MARG, 32'h0004_0010);
		rd_chk(ADDR_MARG, 32'h0004_0010);
		trig();
		t = lastTrig;
		hit(4'h2, t + 5, 7'h11);
		n = 0;
		repeat (30) begin
			@(posedge ref_clk);
			if (roValid === 1'h1)
				n++;
		end
		chk(n == 0, "late window answered early");
		expData.push_back({W_DATA, 4'h2, 5'h0, 12'(t + 5), 7'h11});
		check_event(t, 4'h0);
		expData.delete();
		$display("test late window done");
		summarize();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		$display("[FAIL] %0t ns watchdog expired", $time);
		summarize();
	end
endmodule
